// File: ttu_regs.vh
// Register map, field positions and reset values of the triple timer unit.
// Included by every design file of the unit; holds definitions only.
`ifndef TTU_REGS_VH
`define TTU_REGS_VH

// Byte address: [7:6] counter index, [5:2] register within counter
`define TTU_AW          8
`define TTU_IDX_MSB     7
`define TTU_IDX_LSB     6
`define TTU_REG_MSB     5
`define TTU_REG_LSB     2

`define TTU_REG_CLK     4'h0
`define TTU_REG_CNT     4'h1
`define TTU_REG_VAL     4'h2
`define TTU_REG_IVL     4'h3
`define TTU_REG_M0      4'h4
`define TTU_REG_M1      4'h5
`define TTU_REG_M2      4'h6
`define TTU_REG_ISR     4'h7
`define TTU_REG_IER     4'h8
`define TTU_REG_EVC     4'h9
`define TTU_REG_EVR     4'ha

// Clock control
`define TTU_CLK_W       18
`define TTU_PS_MSB      15
`define TTU_PS_LSB      0
`define TTU_SRC_MSB     17
`define TTU_SRC_LSB     16
`define TTU_SRC_BUS     2'h0
`define TTU_SRC_FAB     2'h1
`define TTU_SRC_PIN     2'h2
`define TTU_PS_MIN      16'h0001

// Counter control
`define TTU_CNT_W       5
`define TTU_CNT_EN      0
`define TTU_CNT_IVL     1
`define TTU_CNT_DN      2
`define TTU_CNT_RST     3
`define TTU_CNT_WAVE    4

// Interrupt causes
`define TTU_INT_W       4
`define TTU_INT_IVL     0
`define TTU_INT_MAT     1
`define TTU_INT_OVF     2
`define TTU_INT_EVO     3

// Event timer control
`define TTU_EVC_W       3
`define TTU_EVC_EN      0
`define TTU_EVC_LO      1
`define TTU_EVC_OV      2
`define TTU_EVT_W       16

// Reset values and limits
`define TTU_CLK_RSTV    18'h00000
`define TTU_CNT_RSTV    5'h00
`define TTU_INT_RSTV    4'h0
`define TTU_EVC_RSTV    3'h0
`define TTU_W32_RSTV    32'h00000000
`define TTU_EVT_RSTV    16'h0000
`define TTU_PSC_RSTV    16'h0000
`define TTU_CNT_MAX     32'hffffffff
`define TTU_EVT_MAX     16'hffff

`define TTU_RESP_OK     2'h0
`define TTU_RESP_SLVERR 2'h2

`endif

// File: ttu_counter.v
// One timer/counter: clock source select, prescaler, 32-bit count,
// match compare and the event timer. Registers live in the parent,
// which latches the one-cycle event pulses this module emits.
`timescale 1ns/1ns
`default_nettype none
`include "ttu_regs.vh"

module ttu_counter (
   // Clock and reset
   input  wire                  sys_clk_in,
   input  wire                  reset_in,
   input  wire                  ce_in,
   // Asynchronous clock sources
   input  wire                  fabric_clk_in,
   input  wire                  pin_clk_in,
   // Settings from the register file
   input  wire [`TTU_CLK_W-1:0] clk_ctrl_in,
   input  wire [`TTU_CNT_W-1:0] cnt_ctrl_in,
   input  wire                  restart_in,
   input  wire [31:0]           interval_in,
   input  wire [31:0]           match0_in,
   input  wire [31:0]           match1_in,
   input  wire [31:0]           match2_in,
   input  wire [`TTU_EVC_W-1:0] evt_ctrl_in,
   // State and events
   output reg  [31:0]           count_out,
   output reg  [`TTU_EVT_W-1:0] event_width_out,
   output reg  [`TTU_INT_W-1:0] events_out,
   output reg                   evt_stop_out,
   output wire                  wave_out
);

   wire [1:0]  raw_src = {pin_clk_in, fabric_clk_in};
   reg  [2:0]  sy [0:1];
   reg  [1:0]  stable;
   wire [1:0]  rise;

   // Three stages; a level counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_sync
         always @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
               sy[g]     <= 3'h0;
               stable[g] <= 1'b0;
            end else if (ce_in) begin
               sy[g] <= {sy[g][1:0], raw_src[g]};
               if (sy[g][1] == sy[g][2])
                  stable[g] <= sy[g][2];
            end
         end
         assign rise[g] = sy[g][1] & sy[g][2] & ~stable[g];
      end
   endgenerate

   wire [1:0]  src = clk_ctrl_in[`TTU_SRC_MSB:`TTU_SRC_LSB];
   wire [15:0] ps  = clk_ctrl_in[`TTU_PS_MSB:`TTU_PS_LSB];
   // Field n divides by n+1; zero is taken as the smallest ratio, two
   wire [15:0] div = (ps == `TTU_PSC_RSTV) ? `TTU_PS_MIN : ps;
   wire        tick = (src == `TTU_SRC_BUS) ? 1'b1 :
                      (src == `TTU_SRC_FAB) ? rise[0] :
                      (src == `TTU_SRC_PIN) ? rise[1] : 1'b0;
   wire        dn  = cnt_ctrl_in[`TTU_CNT_DN];
   wire        ivl = cnt_ctrl_in[`TTU_CNT_IVL];

   reg  [15:0] psc;
   reg  [31:0] next_count;
   reg         hit_ivl;
   reg         hit_ovf;
   wire        hit_mat = (next_count == match0_in) | (next_count == match1_in) |
                         (next_count == match2_in);

   always @* begin
      next_count = count_out + 32'h1;
      hit_ivl    = 1'b0;
      hit_ovf    = 1'b0;
      if (dn) begin
         if (count_out == `TTU_W32_RSTV) begin
            if (ivl) begin
               next_count = interval_in;
               hit_ivl    = 1'b1;
            end else begin
               next_count = `TTU_CNT_MAX;
               hit_ovf    = 1'b1;
            end
         end else begin
            next_count = count_out - 32'h1;
         end
      end else if (ivl && count_out == interval_in) begin
         next_count = `TTU_W32_RSTV;
         hit_ivl    = 1'b1;
      end else if (!ivl && count_out == `TTU_CNT_MAX) begin
         next_count = `TTU_W32_RSTV;
         hit_ovf    = 1'b1;
      end
   end

   // Event timer on the bus clock, measuring the pin pulse
   reg  [`TTU_EVT_W-1:0] evt_cnt;
   reg                   evt_ovf;
   reg                   phase_d;
   wire phase = evt_ctrl_in[`TTU_EVC_LO] ? ~stable[1] : stable[1];

   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         count_out       <= `TTU_W32_RSTV;
         psc             <= `TTU_PSC_RSTV;
         events_out      <= `TTU_INT_RSTV;
         evt_stop_out    <= 1'b0;
         event_width_out <= `TTU_EVT_RSTV;
         evt_cnt         <= `TTU_EVT_RSTV;
         evt_ovf         <= 1'b0;
         phase_d         <= 1'b0;
      end else if (ce_in) begin
         events_out   <= `TTU_INT_RSTV;
         evt_stop_out <= 1'b0;
         if (restart_in) begin
            count_out <= dn && ivl ? interval_in : `TTU_W32_RSTV;
            psc       <= `TTU_PSC_RSTV;
         end else if (cnt_ctrl_in[`TTU_CNT_EN] && tick) begin
            if (psc >= div) begin
               psc                     <= `TTU_PSC_RSTV;
               count_out               <= next_count;
               events_out[`TTU_INT_IVL] <= hit_ivl;
               events_out[`TTU_INT_OVF] <= hit_ovf;
               events_out[`TTU_INT_MAT] <= hit_mat;
            end else begin
               psc <= psc + 16'h1;
            end
         end
         phase_d <= phase;
         if (!evt_ctrl_in[`TTU_EVC_EN]) begin
            evt_cnt <= `TTU_EVT_RSTV;
            evt_ovf <= 1'b0;
         end else if (phase) begin
            if (evt_cnt == `TTU_EVT_MAX) begin
               events_out[`TTU_INT_EVO] <= 1'b1;
               evt_ovf                  <= 1'b1;
               evt_cnt                  <= `TTU_EVT_RSTV;
               evt_stop_out             <= ~evt_ctrl_in[`TTU_EVC_OV];
            end else begin
               evt_cnt <= evt_cnt + 16'h1;
            end
         end else begin
            // Overflowed pulses leave the old width in place
            if (phase_d && !evt_ovf && evt_cnt != `TTU_EVT_RSTV)
               event_width_out <= evt_cnt;
            evt_cnt <= `TTU_EVT_RSTV;
            evt_ovf <= 1'b0;
         end
      end
   end

   assign wave_out = cnt_ctrl_in[`TTU_CNT_WAVE] & (count_out < match0_in);

endmodule
`default_nettype wire

// File: ttu_top.v
// Triple timer unit: AXI4-Lite register file and three counters.
// Assumes one bus clock; source clocks and pins are asynchronous.
//
// Behaviour
// - Three independent 32-bit counters, each with own value, settings, interrupt.
// - Count source is bus clock, fabric clock or multiplexed I/O pin.
// - Prescaler divides the selected source by 2 up to 65536.
// - Each counter holds its own prescale ratio and source selection.
// - Counters count up or down; interval or overflow mode, event timer alongside.
// - Count compared with three match values; any equality raises match cause.
// - Match detection works in every mode.
// - Reset gives overflow mode, bus clock, stopped, interrupts, event, wave off.
// - Interrupt line registered: high the cycle after a cause and its enable are both set.
// - Causes held until status read; that read returns then clears them.
// - Four causes: interval, match, overflow, event overflow; one line per counter.
// - Three interrupt outputs, one per counter.
// - Interval bit clear means overflow mode over the full 32-bit range.
// - Counting up in overflow mode, all ones wraps to zero and sets overflow cause.
// - Counting down in overflow mode, zero sets overflow cause and wraps to all ones.
// - One shared 32-bit programming port reaches all three counters.
// - Interval bit set limits counting to the programmed interval value.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "ttu_regs.vh"

module ttu_top #(
   parameter NUM = 3
) (
   // Clock, reset, enable
   input  wire                 sys_clk_in,
   input  wire                 reset_in,
   input  wire                 ce_in,
   // AXI4-Lite write address
   input  wire [`TTU_AW-1:0]   s_axi_awaddr_in,
   input  wire                 s_axi_awvalid_in,
   output reg                  s_axi_awready_out,
   // AXI4-Lite write data
   input  wire [31:0]          s_axi_wdata_in,
   input  wire [3:0]           s_axi_wstrb_in,
   input  wire                 s_axi_wvalid_in,
   output reg                  s_axi_wready_out,
   // AXI4-Lite write response
   output reg  [1:0]           s_axi_bresp_out,
   output reg                  s_axi_bvalid_out,
   input  wire                 s_axi_bready_in,
   // AXI4-Lite read
   input  wire [`TTU_AW-1:0]   s_axi_araddr_in,
   input  wire                 s_axi_arvalid_in,
   output reg                  s_axi_arready_out,
   output reg  [31:0]          s_axi_rdata_out,
   output reg  [1:0]           s_axi_rresp_out,
   output reg                  s_axi_rvalid_out,
   input  wire                 s_axi_rready_in,
   // Count sources
   input  wire [NUM-1:0]       fabric_clk_in,
   input  wire [NUM-1:0]       multiplexed_io_pin_in,
   // Timer outputs
   output reg  [NUM-1:0]       waveform_out,
   output reg  [NUM-1:0]       irq_out
);

   // Register file, one set per counter
   reg  [`TTU_CLK_W-1:0] clk_ctrl [0:NUM-1];
   reg  [`TTU_CNT_W-1:0] cnt_ctrl [0:NUM-1];
   reg  [31:0]           interval [0:NUM-1];
   reg  [31:0]           match0   [0:NUM-1];
   reg  [31:0]           match1   [0:NUM-1];
   reg  [31:0]           match2   [0:NUM-1];
   reg  [`TTU_INT_W-1:0] int_stat [0:NUM-1];
   reg  [`TTU_INT_W-1:0] int_en   [0:NUM-1];
   reg  [`TTU_EVC_W-1:0] evt_ctrl [0:NUM-1];
   reg  [NUM-1:0]        restart;

   wire [31:0]           cnt_val  [0:NUM-1];
   wire [`TTU_EVT_W-1:0] evt_val  [0:NUM-1];
   wire [`TTU_INT_W-1:0] evt_ev   [0:NUM-1];
   wire [NUM-1:0]        evt_stop;
   wire [NUM-1:0]        wave_w;

   // Address decode shared by the read and write paths
   function mapped;
      input [`TTU_AW-1:0] a;
      begin
         mapped = ({30'h0, a[`TTU_IDX_MSB:`TTU_IDX_LSB]} < NUM) &&
                  (a[`TTU_REG_MSB:`TTU_REG_LSB] <= `TTU_REG_EVR);
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b])
               merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // Register view; reserved bits read as zero
   function [31:0] reg_view;
      input [`TTU_AW-1:0] a;
      reg   [1:0]         k;
      begin
         k = a[`TTU_IDX_MSB:`TTU_IDX_LSB];
         reg_view = `TTU_W32_RSTV;
         if (mapped(a)) begin
            case (a[`TTU_REG_MSB:`TTU_REG_LSB])
               `TTU_REG_CLK: reg_view[`TTU_CLK_W-1:0] = clk_ctrl[k];
               `TTU_REG_CNT: reg_view[`TTU_CNT_W-1:0] = cnt_ctrl[k];
               `TTU_REG_VAL: reg_view = cnt_val[k];
               `TTU_REG_IVL: reg_view = interval[k];
               `TTU_REG_M0:  reg_view = match0[k];
               `TTU_REG_M1:  reg_view = match1[k];
               `TTU_REG_M2:  reg_view = match2[k];
               `TTU_REG_ISR: reg_view[`TTU_INT_W-1:0] = int_stat[k];
               `TTU_REG_IER: reg_view[`TTU_INT_W-1:0] = int_en[k];
               `TTU_REG_EVC: reg_view[`TTU_EVC_W-1:0] = evt_ctrl[k];
               `TTU_REG_EVR: reg_view[`TTU_EVT_W-1:0] = evt_val[k];
               default:      reg_view = `TTU_W32_RSTV;
            endcase
         end
      end
   endfunction

   // Write channel: address and data are taken in either order
   reg                 aw_held;
   reg                 w_held;
   reg [`TTU_AW-1:0]   aw_addr;
   reg [31:0]          w_data;
   reg [3:0]           w_strb;

   wire aw_fire = s_axi_awvalid_in & s_axi_awready_out;
   wire w_fire  = s_axi_wvalid_in & s_axi_wready_out;
   wire do_wr   = aw_held & w_held;
   wire next_aw_held = aw_fire | (aw_held & ~do_wr);
   wire next_w_held  = w_fire | (w_held & ~do_wr);
   wire next_bvalid  = do_wr | (s_axi_bvalid_out & ~s_axi_bready_in);

   wire [1:0]  wk   = aw_addr[`TTU_IDX_MSB:`TTU_IDX_LSB];
   wire [3:0]  wr   = aw_addr[`TTU_REG_MSB:`TTU_REG_LSB];
   wire        wmap = mapped(aw_addr);
   wire [31:0] wval = merge(reg_view(aw_addr), w_data, w_strb);

   // Read channel: one read at a time
   wire ar_fire     = s_axi_arvalid_in & s_axi_arready_out;
   wire next_rvalid = ar_fire | (s_axi_rvalid_out & ~s_axi_rready_in);
   wire [1:0] rk    = s_axi_araddr_in[`TTU_IDX_MSB:`TTU_IDX_LSB];
   wire rd_isr      = ar_fire && mapped(s_axi_araddr_in) &&
                      s_axi_araddr_in[`TTU_REG_MSB:`TTU_REG_LSB] == `TTU_REG_ISR;

   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         aw_held           <= 1'b0;
         w_held            <= 1'b0;
         aw_addr           <= {`TTU_AW{1'b0}};
         w_data            <= `TTU_W32_RSTV;
         w_strb            <= 4'h0;
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out  <= 1'b1;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= `TTU_RESP_OK;
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= `TTU_W32_RSTV;
         s_axi_rresp_out   <= `TTU_RESP_OK;
      end else if (ce_in) begin
         aw_held           <= next_aw_held;
         w_held            <= next_w_held;
         s_axi_awready_out <= ~next_aw_held & ~next_bvalid;
         s_axi_wready_out  <= ~next_w_held & ~next_bvalid;
         s_axi_bvalid_out  <= next_bvalid;
         s_axi_arready_out <= ~next_rvalid;
         s_axi_rvalid_out  <= next_rvalid;
         if (aw_fire)
            aw_addr <= s_axi_awaddr_in;
         if (w_fire) begin
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (do_wr)
            s_axi_bresp_out <= wmap ? `TTU_RESP_OK : `TTU_RESP_SLVERR;
         if (ar_fire) begin
            s_axi_rdata_out <= reg_view(s_axi_araddr_in);
            s_axi_rresp_out <= mapped(s_axi_araddr_in) ? `TTU_RESP_OK : `TTU_RESP_SLVERR;
         end
      end
   end

   // Register updates; read-only registers ignore writes
   integer k;
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         for (k = 0; k < NUM; k = k + 1) begin
            clk_ctrl[k] <= `TTU_CLK_RSTV;
            cnt_ctrl[k] <= `TTU_CNT_RSTV;
            interval[k] <= `TTU_W32_RSTV;
            match0[k]   <= `TTU_W32_RSTV;
            match1[k]   <= `TTU_W32_RSTV;
            match2[k]   <= `TTU_W32_RSTV;
            int_stat[k] <= `TTU_INT_RSTV;
            int_en[k]   <= `TTU_INT_RSTV;
            evt_ctrl[k] <= `TTU_EVC_RSTV;
         end
         restart <= {NUM{1'b0}};
         irq_out <= {NUM{1'b0}};
         waveform_out <= {NUM{1'b0}};
      end else if (ce_in) begin
         for (k = 0; k < NUM; k = k + 1) begin
            restart[k] <= 1'b0;
            if (do_wr && wmap && wk == k) begin
               case (wr)
                  `TTU_REG_CLK: clk_ctrl[k] <= wval[`TTU_CLK_W-1:0];
                  `TTU_REG_CNT: begin
                     // Restart bit acts once and reads back as zero
                     cnt_ctrl[k] <= wval[`TTU_CNT_W-1:0] & ~(5'h1 << `TTU_CNT_RST);
                     restart[k]  <= wval[`TTU_CNT_RST];
                  end
                  `TTU_REG_IVL: interval[k] <= wval;
                  `TTU_REG_M0:  match0[k]   <= wval;
                  `TTU_REG_M1:  match1[k]   <= wval;
                  `TTU_REG_M2:  match2[k]   <= wval;
                  `TTU_REG_IER: int_en[k]   <= wval[`TTU_INT_W-1:0];
                  `TTU_REG_EVC: evt_ctrl[k] <= wval[`TTU_EVC_W-1:0];
                  default: ;
               endcase
            end
            // Overflow with wrap disabled stops the event timer
            if (evt_stop[k])
               evt_ctrl[k][`TTU_EVC_EN] <= 1'b0;
            // A new cause wins over the clearing read in the same cycle
            int_stat[k] <= ((rd_isr && rk == k) ? `TTU_INT_RSTV : int_stat[k]) | evt_ev[k];
            irq_out[k]      <= |(int_stat[k] & int_en[k]);
            waveform_out[k] <= wave_w[k];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM; g = g + 1) begin : g_cnt
         ttu_counter u_cnt (
            .sys_clk_in      (sys_clk_in),
            .reset_in        (reset_in),
            .ce_in           (ce_in),
            .fabric_clk_in   (fabric_clk_in[g]),
            .pin_clk_in      (multiplexed_io_pin_in[g]),
            .clk_ctrl_in     (clk_ctrl[g]),
            .cnt_ctrl_in     (cnt_ctrl[g]),
            .restart_in      (restart[g]),
            .interval_in     (interval[g]),
            .match0_in       (match0[g]),
            .match1_in       (match1[g]),
            .match2_in       (match2[g]),
            .evt_ctrl_in     (evt_ctrl[g]),
            .count_out       (cnt_val[g]),
            .event_width_out (evt_val[g]),
            .events_out      (evt_ev[g]),
            .evt_stop_out    (evt_stop[g]),
            .wave_out        (wave_w[g])
         );
      end
   endgenerate

endmodule
`default_nettype wire

// File: ttu_top_asserts.sv
// Port checks for ttu_top, bound in from the bench.
// Assumes ce_in is held high while the bench runs.
`timescale 1ns/1ns
`default_nettype none
module ttu_chk #(
   parameter NUM = 3
) (
   input wire logic           sys_clk_in,
   input wire logic           reset_in,
   input wire logic           s_axi_awvalid_in,
   input wire logic           s_axi_awready_out,
   input wire logic           s_axi_wvalid_in,
   input wire logic           s_axi_wready_out,
   input wire logic           s_axi_bvalid_out,
   input wire logic           s_axi_bready_in,
   input wire logic [7:0]     s_axi_araddr_in,
   input wire logic           s_axi_arvalid_in,
   input wire logic           s_axi_arready_out,
   input wire logic [1:0]     s_axi_rresp_out,
   input wire logic           s_axi_rvalid_out,
   input wire logic           s_axi_rready_in,
   input wire logic [NUM-1:0] irq_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   // Enables clear at reset, so no line may rise before a write lands
   logic seen_wr;
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in)
         seen_wr <= 1'b0;
      else if (s_axi_bvalid_out)
         seen_wr <= 1'b1;
   end
   property p_irq_off; !seen_wr |-> irq_out == '0; endproperty
   a_irq_off: assert property (p_irq_off) else $error("early irq");
   property p_rst; $fell(reset_in) |-> s_axi_awready_out && s_axi_arready_out && !s_axi_bvalid_out; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_r_lat; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
   a_r_lat: assert property (p_r_lat) else $error("late read");
   property p_ar_wait; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
   a_ar_wait: assert property (p_ar_wait) else $error("read overlap");
   property p_r_done; s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out; endproperty
   a_r_done: assert property (p_r_done) else $error("read not closed");
   property p_slverr; s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:6] == 2'h3
      |=> s_axi_rresp_out == 2'h2; endproperty
   a_slverr: assert property (p_slverr) else $error("no read error");
   property p_b_lat; s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> !s_axi_awready_out && !s_axi_wready_out ##1 s_axi_bvalid_out; endproperty
   a_b_lat: assert property (p_b_lat) else $error("bad write timing");
   property p_b_done; s_axi_bvalid_out && s_axi_bready_in
      |=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out; endproperty
   a_b_done: assert property (p_b_done) else $error("write not closed");
endmodule
`default_nettype wire

// File: ttu_host.sv
// Bus master model for the unit's AXI4-Lite port, one request at a time.
// Assumes a free-running clock; hang_out flags an unanswered request.
`timescale 1ns/1ns
`default_nettype none
module ttu_host (
   input  wire logic        sys_clk_in,
   output logic [7:0]       awaddr_out,
   output logic             awvalid_out,
   input  wire logic        awready_in,
   output logic [31:0]      wdata_out,
   output logic             wvalid_out,
   input  wire logic        wready_in,
   input  wire logic [1:0]  bresp_in,
   input  wire logic        bvalid_in,
   output logic             bready_out,
   output logic [7:0]       araddr_out,
   output logic             arvalid_out,
   input  wire logic        arready_in,
   input  wire logic [31:0] rdata_in,
   input  wire logic [1:0]  rresp_in,
   input  wire logic        rvalid_in,
   output logic             rready_out,
   output logic             hang_out
);
   initial begin
      {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
      {araddr_out, arvalid_out, rready_out, hang_out} = '0;
   end
   // Released lines show the inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      integer n;
      @(posedge sys_clk_in);
      awaddr_out <= a;
      awvalid_out <= 1'b1;
      wdata_out <= d;
      wvalid_out <= 1'b1;
      bready_out <= 1'b1;
      for (n = 0; n < 64 && !bvalid_in; n = n + 1) begin
         @(posedge sys_clk_in);
         if (awready_in) begin
            awvalid_out <= 1'b0;
            awaddr_out <= ~a;
         end
         if (wready_in) begin
            wvalid_out <= 1'b0;
            wdata_out <= ~d;
         end
      end
      r = bresp_in;
      bready_out <= 1'b0;
      hang_out <= n >= 64;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      integer n;
      @(posedge sys_clk_in);
      araddr_out <= a;
      arvalid_out <= 1'b1;
      rready_out <= 1'b1;
      for (n = 0; n < 64 && !rvalid_in; n = n + 1) begin
         @(posedge sys_clk_in);
         if (arready_in) begin
            arvalid_out <= 1'b0;
            araddr_out <= ~a;
         end
      end
      d = rdata_in;
      r = rresp_in;
      rready_out <= 1'b0;
      hang_out <= n >= 64;
   endtask
endmodule
`default_nettype wire

// File: ttu_top_tb.sv
// Bench for ttu_top: register model, overflow, interval and source checks.
// Assumes ttu_host drives the bus; ttu_chk is bound in below.
`timescale 1ns/1ns
`default_nettype none
module ttu_top_tb;
   logic        clk;
   logic        rst;
   logic [2:0]  fab;
   logic [31:0] model [0:63];
   integer      bad_count;
   integer      comparisons;
   integer      k;
   wire  [7:0]  awa, ara;
   wire  [31:0] wd, rdat;
   wire  [1:0]  br, rr;
   wire         awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry, hang;
   wire  [2:0]  wave, irq;
   ttu_top #(.NUM(3)) ttu_top_i (.sys_clk_in(clk), .reset_in(rst), .ce_in(1'b1), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
      .fabric_clk_in(fab), .multiplexed_io_pin_in(3'h0), .waveform_out(wave), .irq_out(irq));
   ttu_host ttu_host_i (.sys_clk_in(clk), .awaddr_out(awa), .awvalid_out(awv), .awready_in(awr), .wdata_out(wd),
      .wvalid_out(wv), .wready_in(wrdy), .bresp_in(br), .bvalid_in(bv), .bready_out(bry), .araddr_out(ara),
      .arvalid_out(arv), .arready_in(arr), .rdata_in(rdat), .rresp_in(rr), .rvalid_in(rv), .rready_out(rry),
      .hang_out(hang));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic [1:0] r;
      ttu_host_i.wr(a, d, r);
      cmp({30'h0, r}, {30'h0, e});
      if (e == 2'h0)
         model[a[7:2]] = d;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [1:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      ttu_host_i.rd(a, d, r);
      cmp({30'h0, r}, {30'h0, e});
      cmp(d & m, model[a[7:2]] & m);
   endtask
   // Every mapped register of the three counters, then the first four offsets of the unmapped fourth
   task automatic scan;
      for (k = 0; k < 52; k = k + 1)
         rreg({k[5:0], 2'h0}, 32'hffffffff, (k > 47 || k[3:0] > 4'ha) ? 2'h2 : 2'h0);
   endtask
   task automatic do_reset;
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (k = 0; k < 64; k = k + 1)
         model[k] = 32'h0;
      scan;
      $display("reset test done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge hang) begin
      bad_count = bad_count + 1;
      end_of_test;
   end
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      fab = 3'h0;
      bad_count = 0;
      comparisons = 0;
      void'($urandom(32'h91f91627));
      do_reset;
      for (k = 0; k < 12; k = k + 1)
         wreg({k[3:2], (k[1:0] == 2'h0) ? 4'h0 : 4'h3 + k[1:0], 2'h0}, $urandom & 32'h0003ffff, 2'h0);
      wreg(8'hc0, 32'h00000005, 2'h2);
      scan;
      $display("register test done");
      wreg(8'h00, 32'h0, 2'h0);
      wreg(8'h04, 32'hd, 2'h0);
      repeat (12) @(negedge clk);
      model[2] = 32'hffffffff;
      rreg(8'h08, 32'hffffff00, 2'h0);
      model[7] = 32'h4;
      rreg(8'h1c, 32'h4, 2'h0);
      model[7] = 32'h0;
      rreg(8'h1c, 32'h4, 2'h0);
      wreg(8'h04, 32'h0, 2'h0);
      $display("down overflow test done");
      wreg(8'h40, 32'h0, 2'h0);
      wreg(8'h4c, 32'h5, 2'h0);
      wreg(8'h54, 32'h3, 2'h0);
      wreg(8'h60, 32'hf, 2'h0);
      wreg(8'h44, 32'hb, 2'h0);
      repeat (30) @(negedge clk);
      cmp({31'h0, irq[1]}, 32'h1);
      cmp({31'h0, irq[0]}, 32'h0);
      model[23] = 32'h3;
      rreg(8'h5c, 32'h3, 2'h0);
      model[18] = 32'h0;
      rreg(8'h48, 32'hfffffff8, 2'h0);
      wreg(8'h60, 32'h0, 2'h0);
      repeat (3) @(negedge clk);
      cmp({31'h0, irq[1]}, 32'h0);
      wreg(8'h44, 32'h0, 2'h0);
      $display("interval test done");
      wreg(8'h80, 32'h00010000, 2'h0);
      wreg(8'h84, 32'h19, 2'h0);
      repeat (8) begin
         repeat (6) @(posedge clk);
         fab[2] <= 1'b1;
         repeat (6) @(posedge clk);
         fab[2] <= 1'b0;
      end
      repeat (8) @(posedge clk);
      model[34] = 32'h4;
      rreg(8'h88, 32'hffffffff, 2'h0);
      cmp({31'h0, wave[2]}, {31'h0, 32'h4 < model[36]});
      $display("fabric source test done");
      do_reset;
      end_of_test;
   end
endmodule
bind ttu_top ttu_chk #(.NUM(NUM)) ttu_chk_i (.*);
`default_nettype wire
